// File: verification/gst_status_regs_asserts.sv
// bus-side assertions for the switch timing status bank
`timescale 1ns/1ns
`include "gst_map.vh"

// ====================================================================
// checker
module gst_status_regs_asserts (
  input wire                   aclk,
  input wire                   aresetn,
  input wire [`GST_ADDR_W-1:0] s_axi_awaddr,
  input wire                   s_axi_awvalid,
  input wire                   s_axi_awready,
  input wire                   s_axi_wvalid,
  input wire                   s_axi_wready,
  input wire [1:0]             s_axi_bresp,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_bready,
  input wire [`GST_ADDR_W-1:0] s_axi_araddr,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire [31:0]            s_axi_rdata,
  input wire [1:0]             s_axi_rresp,
  input wire                   s_axi_rvalid,
  input wire                   s_axi_rready
);
  // low address bits are ignored, only the word index selects
  wire [4:0] ri = s_axi_araddr[6:2];
  wire [4:0] wi = s_axi_awaddr[6:2];
  wire rmap = ri >= `GST_IDX_PWM1_DELAY && ri <= `GST_IDX_PWM3_EDGE;
  wire wmap = wi >= `GST_IDX_PWM1_DELAY && wi <= `GST_IDX_PWM3_EDGE;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_ask;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  sequence wr_ask;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_wready
      && !s_axi_bvalid;
  endsequence
  sequence wr_done;
    (s_axi_awready && s_axi_wready) ##1 s_axi_bvalid;
  endsequence

  rd_latency_a: assert property (rd_ask |=>
    (s_axi_arready && !s_axi_rvalid) ##1 s_axi_rvalid)
    else $error("read answer out of time");
  rd_unmap_a: assert property (rd_ask ##0 !rmap |-> ##2
    s_axi_rresp == `GST_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  rd_map_a: assert property (rd_ask ##0 rmap |-> ##2
    s_axi_rresp == 2'b00)
    else $error("mapped read refused");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  wr_flow_a: assert property (wr_ask |-> ##1 wr_done)
    else $error("write answer out of time");
  wr_unmap_a: assert property (wr_ask ##0 !wmap |-> ##2
    s_axi_bresp == `GST_RESP_SLVERR) else $error("unmapped write accepted");
  wr_map_a: assert property (wr_ask ##0 wmap |-> ##2
    s_axi_bresp == `GST_RESP_OKAY) else $error("mapped write refused");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
endmodule

bind gst_status_regs gst_status_regs_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: verification/gst_status_regs_tb.sv
// self-checking bench for the switch timing status bank
`timescale 1ns/1ns
`include "gst_map.vh"

// ====================================================================
// bench
module gst_status_regs_tb;
  // short step keeps the saturation case under a few thousand cycles
  localparam ST = 2;
  reg         aclk = 0;
  reg         aresetn = 0;
  reg  [2:0]  pwm = 0, sst = 0, sdn = 0;
  reg  [6:0]  awa = 0, ara = 0;
  reg  [31:0] wdt = 0;
  reg         awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  wire        awr, wrd, bv, arr, rv;
  wire [1:0]  bre, rre;
  wire [31:0] rdt;
  integer     err_total = 0, num_checks = 0, seed = 65399, i, k, ch;
  reg  [31:0] d;
  reg  [1:0]  r;
  integer     t [0:3];

  always #2 aclk = ~aclk;

  gst_status_regs #(.STEP_CYC(ST)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .pwm_in(pwm), .sw_start_in(sst),
    .sw_done_in(sdn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdt), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rry));

  // expected field: whole steps, pinned at the top instead of wrapping
  function [7:0] ex(input integer n);
    ex = (n / ST > 255) ? 8'hFF : n / ST;
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task stall;
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t bus never answered", $time);
      close_out;
    end
  endtask

  // one read; request held until arready is seen, then wait for the answer
  task axi_rd(input [6:0] a);
    integer n, ok;
    begin
      ok = 0;
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      for (n = 0; n < 40 && !ok; n = n + 1)
      begin
        @(posedge aclk);
        if (arr === 1'b1) arv <= 0;
        if (rv === 1'b1)
        begin
          d = rdt;
          r = rre;
          rry <= 0;
          ok = 1;
        end
      end
      if (!ok) stall;
    end
  endtask

  // one write; address and data offered together, random payload
  task axi_wr(input [6:0] a);
    integer n, ok;
    begin
      ok = 0;
      @(posedge aclk);
      awa <= a;
      wdt <= $random(seed);
      awv <= 1;
      wv <= 1;
      bry <= 1;
      for (n = 0; n < 40 && !ok; n = n + 1)
      begin
        @(posedge aclk);
        if (awr === 1'b1) awv <= 0;
        if (wrd === 1'b1) wv <= 0;
        if (bv === 1'b1)
        begin
          r = bre;
          bry <= 0;
          ok = 1;
        end
      end
      if (!ok) stall;
    end
  endtask

  // turn-on, rise, turn-off, fall on one channel, spaced by t[]
  task meas(input integer c);
    begin
      pwm[c] <= 1;
      repeat (t[0]) @(posedge aclk);
      sst[c] <= 1;
      repeat (t[1]) @(posedge aclk);
      sdn[c] <= 1;
      repeat (8) @(posedge aclk);
      sst[c] <= 0;
      sdn[c] <= 0;
      repeat (8) @(posedge aclk);
      pwm[c] <= 0;
      repeat (t[2]) @(posedge aclk);
      sst[c] <= 1;
      repeat (t[3]) @(posedge aclk);
      sdn[c] <= 1;
      repeat (8) @(posedge aclk);
      sst[c] <= 0;
      sdn[c] <= 0;
      repeat (8) @(posedge aclk);
    end
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    // six words read zero after reset; the next index is unmapped
    for (i = 0; i < 7; i = i + 1)
    begin
      axi_rd(7'h50 + 4 * i);
      chk(d, 0);
      chk(r, i < 6 ? 0 : 2);
    end
    $display("test reset values done");
    // first pass has the boundary counts, the rest are random
    for (i = 0; i < 6; i = i + 1)
    begin
      ch = i % 3;
      for (k = 0; k < 4; k = k + 1)
        t[k] = {$random(seed)} % 200 + 1;
      if (i == 0)
      begin
        t[0] = 3;
        t[1] = 510;
        t[2] = 513;
        t[3] = 1;
      end
      meas(ch);
      axi_rd(7'h50 + 4 * ch);
      chk(d, {ex(t[2]), ex(t[0])});
      axi_rd(7'h5C + 4 * ch);
      chk(d, {ex(t[3]), ex(t[1])});
      axi_wr(7'h50 + 4 * ch);
      chk(r, 0);
      axi_rd(7'h50 + 4 * ch);
      chk(d, {ex(t[2]), ex(t[0])});
      $display("test channel %0d pass %0d done", ch + 1, i);
    end
    axi_wr(7'h4C);
    chk(r, 2);
    close_out;
  end
endmodule

// File: verilog/gst_interval.v
// measures one switching interval in steps of STEP_CYC clocks (16 by default, 64 ns at 4 ns per clock) with saturation
`timescale 1ns/1ns
`include "gst_map.vh"

module gst_interval #(
  parameter STEP_CYC = `GST_STEP_CYC
)(
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       start,
  input  wire       stop,
  output reg  [7:0] count_q,
  output reg        done_q
);

  reg        run_q;
  reg [7:0]  cyc_q;
  reg [7:0]  cnt_q;
  wire       step_hit;

  assign step_hit = (cyc_q == STEP_CYC[7:0] - 8'h01);

  // ==================================================================
  // interval counter; start restarts, stop latches the result
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q   <= 1'b0;
      cyc_q   <= 8'h00;
      cnt_q   <= 8'h00;
      count_q <= 8'h00;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        run_q <= 1'b1;
        cyc_q <= 8'h00;
        cnt_q <= 8'h00;
      end
      else if (run_q && stop)
      begin
        run_q   <= 1'b0;
        // the stop edge closes the last cycle of the interval
        if (step_hit && cnt_q != `GST_FIELD_MAX)
          count_q <= cnt_q + 8'h01;
        else
          count_q <= cnt_q;
        done_q  <= 1'b1;
      end
      else if (run_q)
      begin
        cyc_q <= step_hit ? 8'h00 : cyc_q + 8'h01;
        // stick at full scale instead of wrapping
        if (step_hit && cnt_q != `GST_FIELD_MAX)
          cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule

// File: verilog/gst_map.vh
// register offsets, field positions and timing constants for the switch timing status bank
`ifndef GST_MAP_VH
`define GST_MAP_VH

// ====================================================================
// register indices (printed offsets) and byte addresses
`define GST_IDX_PWM1_DELAY   5'h14
`define GST_IDX_PWM2_DELAY   5'h15
`define GST_IDX_PWM3_DELAY   5'h16
`define GST_IDX_PWM1_EDGE    5'h17
`define GST_IDX_PWM2_EDGE    5'h18
`define GST_IDX_PWM3_EDGE    5'h19
`define GST_ADDR_LSB         2
`define GST_ADDR_W           7

// ====================================================================
// field layout
`define GST_HI_MSB           15
`define GST_HI_LSB           8
`define GST_LO_MSB           7
`define GST_LO_LSB           0
`define GST_FIELD_W          8
`define GST_FIELD_MAX        8'hFF
`define GST_REG_RESET        16'h0000

// ====================================================================
// timing: one count is 62.5 ns; at 4 ns per clock that is 15.625 cycles
`define GST_STEP_PS          62500
`define GST_CLK_PS           4000
// a step counts from 0 to one below this value: 16 cycles, the least whole count
`define GST_STEP_CYC ((`GST_STEP_PS + `GST_CLK_PS - 1) / `GST_CLK_PS)

// ====================================================================
// axi responses
`define GST_RESP_OKAY        2'b00
`define GST_RESP_SLVERR      2'b10

`endif

// File: verilog/gst_status_regs.v
// read-only switching timing status bank behind an axi4-lite slave
// Functional notes
// - ch1 turn-off delay in bits 15:8, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns), read-only
// - ch1 turn-on delay in bits 7:0, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - ch2 turn-off delay in bits 15:8, unsigned, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - ch2 turn-on delay in bits 7:0, unsigned, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - ch3 turn-off delay in bits 15:8, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - ch3 turn-on delay in bits 7:0, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - ch1 fall time in bits 15:8, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns), read-only
// - ch1 rise time in bits 7:0, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns), read-only
// - ch2 fall time in bits 15:8, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - ch2 rise time in bits 7:0, 62.5 ns per count (here 16 clocks of 4 ns, 64 ns)
// - delay registers at 0x14, 0x15, 0x16, resetting to zero
// - edge time registers ch1 at 0x17, ch2 at 0x18, reset zero
// - ch3 fall/rise at 0x19, same layout, reset zero
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "gst_map.vh"

module gst_status_regs #(
  parameter NCH      = 3,
  parameter STEP_CYC = `GST_STEP_CYC
)(
  input  wire                      aclk,
  input  wire                      aresetn,
  // per channel: pwm command and sensed gate/switch-node markers
  input  wire [NCH-1:0]            pwm_in,
  input  wire [NCH-1:0]            sw_start_in,
  input  wire [NCH-1:0]            sw_done_in,
  // axi4-lite slave
  input  wire [`GST_ADDR_W-1:0]    s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`GST_ADDR_W-1:0]    s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready
);

  // ==================================================================
  // pin synchronisers: two flops before any logic looks
  reg  [NCH-1:0] pwm_s1_q;
  reg  [NCH-1:0] pwm_s2_q;
  reg  [NCH-1:0] pwm_d_q;
  reg  [NCH-1:0] st_s1_q;
  reg  [NCH-1:0] st_s2_q;
  reg  [NCH-1:0] st_d_q;
  reg  [NCH-1:0] dn_s1_q;
  reg  [NCH-1:0] dn_s2_q;
  reg  [NCH-1:0] dn_d_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_s1_q <= {NCH{1'b0}};
      pwm_s2_q <= {NCH{1'b0}};
      pwm_d_q  <= {NCH{1'b0}};
      st_s1_q  <= {NCH{1'b0}};
      st_s2_q  <= {NCH{1'b0}};
      st_d_q   <= {NCH{1'b0}};
      dn_s1_q  <= {NCH{1'b0}};
      dn_s2_q  <= {NCH{1'b0}};
      dn_d_q   <= {NCH{1'b0}};
    end
    else
    begin
      pwm_s1_q <= pwm_in;
      pwm_s2_q <= pwm_s1_q;
      pwm_d_q  <= pwm_s2_q;
      st_s1_q  <= sw_start_in;
      st_s2_q  <= st_s1_q;
      st_d_q   <= st_s2_q;
      dn_s1_q  <= sw_done_in;
      dn_s2_q  <= dn_s1_q;
      dn_d_q   <= dn_s2_q;
    end
  end

  // ==================================================================
  // edge events, second synchroniser stage compared with its delayed copy
  wire [NCH-1:0] pwm_rise = pwm_s2_q & ~pwm_d_q;
  wire [NCH-1:0] pwm_fall = ~pwm_s2_q & pwm_d_q;
  wire [NCH-1:0] st_rise  = st_s2_q & ~st_d_q;
  wire [NCH-1:0] dn_rise  = dn_s2_q & ~dn_d_q;

  // ==================================================================
  // four measurements per channel: turn-on delay, turn-off delay,
  // rise time, fall time; a delay spans command edge to switch start,
  // an edge time spans switch start to switch done
  wire [8*NCH-1:0] ton_cnt;
  wire [8*NCH-1:0] toff_cnt;
  wire [8*NCH-1:0] rise_cnt;
  wire [8*NCH-1:0] fall_cnt;
  wire [NCH-1:0]   ton_done;
  wire [NCH-1:0]   toff_done;
  wire [NCH-1:0]   rise_done;
  wire [NCH-1:0]   fall_done;
  reg  [NCH-1:0]   dir_q;
  reg  [16*NCH-1:0] dly_q;
  reg  [16*NCH-1:0] edg_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      // counters saturate internally, never wrap
      gst_interval #(.STEP_CYC(STEP_CYC)) u_ton (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (pwm_rise[g]),
        .stop    (st_rise[g]),
        .count_q (ton_cnt[8*g+7:8*g]),
        .done_q  (ton_done[g])
      );
      gst_interval #(.STEP_CYC(STEP_CYC)) u_toff (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (pwm_fall[g]),
        .stop    (st_rise[g]),
        .count_q (toff_cnt[8*g+7:8*g]),
        .done_q  (toff_done[g])
      );
      gst_interval #(.STEP_CYC(STEP_CYC)) u_rise (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (st_rise[g] & dir_q[g]),
        .stop    (dn_rise[g]),
        .count_q (rise_cnt[8*g+7:8*g]),
        .done_q  (rise_done[g])
      );
      gst_interval #(.STEP_CYC(STEP_CYC)) u_fall (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (st_rise[g] & ~dir_q[g]),
        .stop    (dn_rise[g]),
        .count_q (fall_cnt[8*g+7:8*g]),
        .done_q  (fall_done[g])
      );

      // last commanded direction picks rise or fall timing
      // status fields load only on a completed measurement
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          dir_q[g]              <= 1'b0;
          dly_q[16*g+15:16*g]   <= `GST_REG_RESET;
          edg_q[16*g+15:16*g]   <= `GST_REG_RESET;
        end
        else
        begin
          if (pwm_rise[g])
            dir_q[g] <= 1'b1;
          else if (pwm_fall[g])
            dir_q[g] <= 1'b0;
          // turn-off delay upper byte
          if (toff_done[g])
            dly_q[16*g+15:16*g+8] <= toff_cnt[8*g+7:8*g];
          // turn-on delay lower byte
          if (ton_done[g])
            dly_q[16*g+7:16*g] <= ton_cnt[8*g+7:8*g];
          // fall upper, rise lower
          if (fall_done[g])
            edg_q[16*g+15:16*g+8] <= fall_cnt[8*g+7:8*g];
          // rise time lower byte
          if (rise_done[g])
            edg_q[16*g+7:16*g] <= rise_cnt[8*g+7:8*g];
        end
      end
    end
  endgenerate

  // ==================================================================
  // write path: accept aw and w in either order, then answer; data are
  // dropped because every field here is read-only
  reg aw_got_q;
  reg w_got_q;
  reg aw_hit_q;
  wire [4:0] aw_idx = s_axi_awaddr[`GST_ADDR_W-1:`GST_ADDR_LSB];
  wire aw_map = (aw_idx >= `GST_IDX_PWM1_DELAY) &&
                (aw_idx <= `GST_IDX_PWM3_EDGE);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GST_RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_hit_q      <= 1'b0;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_got_q && !s_axi_awready && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
        aw_got_q      <= 1'b1;
        aw_hit_q      <= aw_map;
      end
      if (s_axi_wvalid && !w_got_q && !s_axi_wready && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
        w_got_q      <= 1'b1;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        // mapped status registers answer okay, holes answer slverr
        s_axi_bresp  <= aw_hit_q ? `GST_RESP_OKAY : `GST_RESP_SLVERR;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==================================================================
  // read path: decode index, upper 16 data bits read as zero
  wire [4:0] ar_idx = s_axi_araddr[`GST_ADDR_W-1:`GST_ADDR_LSB];
  reg  [15:0] rd_word;
  reg         rd_hit;

  always @*
  begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (ar_idx)
      `GST_IDX_PWM1_DELAY: rd_word = dly_q[15:0];
      `GST_IDX_PWM2_DELAY: rd_word = dly_q[31:16];
      `GST_IDX_PWM3_DELAY: rd_word = dly_q[47:32];
      `GST_IDX_PWM1_EDGE:  rd_word = edg_q[15:0];
      `GST_IDX_PWM2_EDGE:  rd_word = edg_q[31:16];
      `GST_IDX_PWM3_EDGE:  rd_word = edg_q[47:32];
      default:             rd_hit  = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GST_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      // data follow the address handshake, never precede it
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= rd_hit ? `GST_RESP_OKAY : `GST_RESP_SLVERR;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
        s_axi_arready <= 1'b1;
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
